// [flags_regs.svh]
`ifndef FLAGS_REGS_SVH
`define FLAGS_REGS_SVH
// register byte addresses
`define FLAGS_ADDR        12'h00c
`define MASK_ADDR         12'h034
`define MODE_ADDR         12'h038
`define ADDR_BITS         12
// flag bit positions
`define BIT_WIDE_OVF      0
`define BIT_PERIOD_MATCH  1
`define BIT_CAPCMP        2
`define BIT_SERIAL        3
// reset values
`define FLAGS_RESET       8'h00
`define MASK_RESET        8'h00
`define MODE_RESET        8'h00
`define LOW_FLAG_MASK     8'h0f
// mode field positions
`define MODE_SER_LO       0
`define MODE_SER_HI       1
`define MODE_CC_LO        2
`define MODE_CC_HI        3
`define MODE_MULTI        4
// axi responses
`define RESP_OKAY         2'h0
`define RESP_SLVERR       2'h2
`endif

// [flags_pkg.sv]
package flags_pkg;
  // serial unit operating mode
  typedef enum logic [1:0] {
    ser_off        = 2'h0,
    ser_shift      = 2'h1,
    ser_bus_target = 2'h2,
    ser_bus_ctrl   = 2'h3
  } serial_mode_type;
  // capture/compare unit mode
  typedef enum logic [1:0] {
    cc_off     = 2'h0,
    cc_capture = 2'h1,
    cc_compare = 2'h2,
    cc_pwm     = 2'h3
  } capcmp_mode_type;
  // event pulses raised by the peripherals
  typedef struct packed {
    logic byte_done;
    logic start_done;
    logic stop_done;
    logic restart_done;
    logic ack_done;
    logic idle_start_seen;
    logic idle_stop_seen;
    logic serial_idle;
    logic capture_taken;
    logic compare_match;
  } periph_events_type;
endpackage

// [sticky_flag.sv]
`timescale 1ns/1ps
// one sticky flag: set wins over write-one clear
module sticky_flag (
  // clock and reset
  input  wire logic clock_in,
  input  wire logic rst_n_in,
  // set and clear
  input  wire logic set_in,
  input  wire logic clear_in,
  // state
  output logic      flag_out
);
  logic flag_r;
  logic flag_nxt;

  // next value
  always_comb begin
    flag_nxt = flag_r;
    if (clear_in) begin
      flag_nxt = 1'b0;
    end
    if (set_in) begin
      flag_nxt = 1'b1;
    end
  end

  // register
  always_ff @(posedge clock_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      flag_r <= 1'b0;
    end else begin
      flag_r <= flag_nxt;
    end
  end

  assign flag_out = flag_r;
endmodule

// [peripheral_interrupt_flags.sv]
// Local design decisions: the address map and the AXI4-Lite slave port.
`timescale 1ns/1ps
`include "flags_regs.svh"
// Notes on behaviour
// - a finished byte transfer sets the serial flag in shift mode and in bus target and controller modes.
// - in bus controller mode, a completed requested start condition sets the serial flag.
// - in bus controller mode, a completed requested stop condition sets the serial flag.
// - in bus controller mode, a completed requested repeated start sets the serial flag.
// - in bus controller mode, a completed requested acknowledge sequence sets the serial flag.
// - with multi-controller enabled, a start seen on the bus while the serial unit idles sets the serial flag.
// - with multi-controller enabled, a stop seen on the bus while the serial unit idles sets the serial flag.
// - the serial flag reads zero unless one of its events happened since software last cleared it.
// - in capture mode, a capture of the wide timer sets the capture/compare flag until software clears it.
// - in compare mode, a match sets the capture/compare flag; in pwm mode it is never set.
// - a rollover of the wide timer sets the overflow flag until cleared; it reads zero otherwise.
// - the flag register sits at address 0ch and all bits are zero after reset.
module peripheral_interrupt_flags
  import flags_pkg::*;
#(
  parameter int PERIOD_WIDTH = 8,
  parameter int WIDE_WIDTH   = 16
) (
  // clock and reset
  input  wire logic                    clock_in,
  input  wire logic                    rst_n_in,
  // peripheral events
  input  wire periph_events_type       events_in,
  input  wire logic [WIDE_WIDTH-1:0]   wide_timer_count_in,
  input  wire logic [PERIOD_WIDTH-1:0] period_timer_count_in,
  input  wire logic [PERIOD_WIDTH-1:0] period_limit_in,
  // axi4-lite write address
  input  wire logic                    awvalid_in,
  output logic                         awready_out,
  input  wire logic [31:0]             awaddr_in,
  // axi4-lite write data
  input  wire logic                    wvalid_in,
  output logic                         wready_out,
  input  wire logic [31:0]             wdata_in,
  input  wire logic [3:0]              wstrb_in,
  // axi4-lite write response
  output logic                         bvalid_out,
  input  wire logic                    bready_in,
  output logic [1:0]                   bresp_out,
  // axi4-lite read address
  input  wire logic                    arvalid_in,
  output logic                         arready_out,
  input  wire logic [31:0]             araddr_in,
  // axi4-lite read data
  output logic                         rvalid_out,
  input  wire logic                    rready_in,
  output logic [31:0]                  rdata_out,
  output logic [1:0]                   rresp_out,
  // interrupt
  output logic                         irq_out
);

  ////////////////////////////////////////////////////////////////////////////
  // state
  logic                    aw_held_r,  aw_held_nxt;
  logic                    w_held_r,   w_held_nxt;
  logic [`ADDR_BITS-1:0]   aw_addr_r,  aw_addr_nxt;
  logic [7:0]              w_data_r,   w_data_nxt;
  logic                    w_lane_r,   w_lane_nxt;
  logic                    bvalid_r,   bvalid_nxt;
  logic [1:0]              bresp_r,    bresp_nxt;
  logic                    rvalid_r,   rvalid_nxt;
  logic [31:0]             rdata_r,    rdata_nxt;
  logic [1:0]              rresp_r,    rresp_nxt;
  logic [7:0]              mask_r,     mask_nxt;
  logic [7:0]              mode_r,     mode_nxt;
  logic                    irq_r,      irq_nxt;
  logic                    awready_r,  awready_nxt;
  logic                    wready_r,   wready_nxt;
  logic                    arready_r,  arready_nxt;
  logic                    period_eq_r, period_eq_nxt;
  logic [WIDE_WIDTH-1:0]   wide_prev_r, wide_prev_nxt;
  logic                    wide_seen_r, wide_seen_nxt;

  logic [3:0]              flag_set;
  logic [3:0]              flag_clear;
  logic [3:0]              flag_q;
  logic [7:0]              flags_byte;
  logic                    do_write;
  serial_mode_type         ser_mode;
  capcmp_mode_type         cc_mode;
  logic                    multi_ctrl;
  logic                    period_eq;
  logic                    wide_roll;

  assign ser_mode   = serial_mode_type'(mode_r[`MODE_SER_HI:`MODE_SER_LO]);
  assign cc_mode    = capcmp_mode_type'(mode_r[`MODE_CC_HI:`MODE_CC_LO]);
  assign multi_ctrl = mode_r[`MODE_MULTI];
  assign flags_byte = {4'h0, flag_q};   // upper flags live elsewhere, read zero
  assign do_write   = aw_held_r && w_held_r && !bvalid_r;

  ////////////////////////////////////////////////////////////////////////////
  // event sources
  assign period_eq = (period_timer_count_in == period_limit_in);
  assign wide_roll = wide_seen_r && (wide_prev_r == {WIDE_WIDTH{1'b1}})
                     && (wide_timer_count_in == '0);

  // set conditions per flag
  always_comb begin
    flag_set = 4'h0;
    flag_set[`BIT_SERIAL] =
        (events_in.byte_done && ser_mode != ser_off)
      | (events_in.start_done && ser_mode == ser_bus_ctrl)
      | (events_in.stop_done && ser_mode == ser_bus_ctrl)
      | (events_in.restart_done && ser_mode == ser_bus_ctrl)
      | (events_in.ack_done && ser_mode == ser_bus_ctrl)
      | (events_in.idle_start_seen && multi_ctrl && events_in.serial_idle)
      | (events_in.idle_stop_seen && multi_ctrl && events_in.serial_idle);
    flag_set[`BIT_CAPCMP] =
        (events_in.capture_taken && cc_mode == cc_capture)
      | (events_in.compare_match && cc_mode == cc_compare);
    flag_set[`BIT_PERIOD_MATCH] = period_eq && !period_eq_r;
    flag_set[`BIT_WIDE_OVF] = wide_roll;
  end

  // write-one clear from software only
  always_comb begin
    flag_clear = 4'h0;
    if (do_write && aw_addr_r == `FLAGS_ADDR && w_lane_r) begin
      flag_clear = w_data_r[3:0];   // only the four low flags exist here
    end
  end

  // one sticky cell per flag, zero at reset
  genvar gi;
  for (gi = 0; gi < 4; gi++) begin : g_flag
    sticky_flag u_flag (
      .clock_in (clock_in),
      .rst_n_in (rst_n_in),
      .set_in   (flag_set[gi]),
      .clear_in (flag_clear[gi]),
      .flag_out (flag_q[gi])
    );
  end

  ////////////////////////////////////////////////////////////////////////////
  // bus slave next state
  always_comb begin
    aw_held_nxt   = aw_held_r;
    w_held_nxt    = w_held_r;
    aw_addr_nxt   = aw_addr_r;
    w_data_nxt    = w_data_r;
    w_lane_nxt    = w_lane_r;
    bvalid_nxt    = bvalid_r;
    bresp_nxt     = bresp_r;
    rvalid_nxt    = rvalid_r;
    rdata_nxt     = rdata_r;
    rresp_nxt     = rresp_r;
    mask_nxt      = mask_r;
    mode_nxt      = mode_r;
    if (awvalid_in && !aw_held_r) begin
      aw_held_nxt = 1'b1;
      aw_addr_nxt = awaddr_in[`ADDR_BITS-1:0];
    end
    if (wvalid_in && !w_held_r) begin
      w_held_nxt = 1'b1;
      w_data_nxt = wdata_in[7:0];
      w_lane_nxt = wstrb_in[0];
    end
    if (do_write) begin
      aw_held_nxt = 1'b0;
      w_held_nxt  = 1'b0;
      bvalid_nxt  = 1'b1;
      bresp_nxt   = `RESP_OKAY;
      case (aw_addr_r)
        `FLAGS_ADDR: ;
        `MASK_ADDR: if (w_lane_r) mask_nxt = w_data_r & `LOW_FLAG_MASK;
        `MODE_ADDR: if (w_lane_r) mode_nxt = w_data_r;
        default:    bresp_nxt = `RESP_SLVERR;
      endcase
    end
    if (bvalid_r && bready_in) begin
      bvalid_nxt = 1'b0;
    end
    if (arvalid_in && !rvalid_r) begin
      rvalid_nxt = 1'b1;
      rresp_nxt  = `RESP_OKAY;
      case (araddr_in[`ADDR_BITS-1:0])
        `FLAGS_ADDR: rdata_nxt = {24'h000000, flags_byte};
        `MASK_ADDR:  rdata_nxt = {24'h000000, mask_r};
        `MODE_ADDR:  rdata_nxt = {24'h000000, mode_r};
        default: begin
          rdata_nxt = 32'h00000000;
          rresp_nxt = `RESP_SLVERR;
        end
      endcase
    end else if (rvalid_r && rready_in) begin
      rvalid_nxt = 1'b0;
    end
  end

  // event edge trackers, ready flags and interrupt
  always_comb begin
    awready_nxt   = !aw_held_nxt;
    wready_nxt    = !w_held_nxt;
    arready_nxt   = !rvalid_nxt;
    period_eq_nxt = period_eq;
    wide_prev_nxt = wide_timer_count_in;
    wide_seen_nxt = 1'b1;
    irq_nxt       = |(flags_byte & mask_r);
  end

  ////////////////////////////////////////////////////////////////////////////
  // registers
  always_ff @(posedge clock_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      aw_held_r   <= 1'b0;
      w_held_r    <= 1'b0;
      aw_addr_r   <= '0;
      w_data_r    <= 8'h00;
      w_lane_r    <= 1'b0;
      bvalid_r    <= 1'b0;
      bresp_r     <= `RESP_OKAY;
      rvalid_r    <= 1'b0;
      rdata_r     <= 32'h00000000;
      rresp_r     <= `RESP_OKAY;
      mask_r      <= `MASK_RESET;
      mode_r      <= `MODE_RESET;
      irq_r       <= 1'b0;
      awready_r   <= 1'b1;
      wready_r    <= 1'b1;
      arready_r   <= 1'b1;
      period_eq_r <= 1'b0;
      wide_prev_r <= '0;
      wide_seen_r <= 1'b0;
    end else begin
      aw_held_r   <= aw_held_nxt;
      w_held_r    <= w_held_nxt;
      aw_addr_r   <= aw_addr_nxt;
      w_data_r    <= w_data_nxt;
      w_lane_r    <= w_lane_nxt;
      bvalid_r    <= bvalid_nxt;
      bresp_r     <= bresp_nxt;
      rvalid_r    <= rvalid_nxt;
      rdata_r     <= rdata_nxt;
      rresp_r     <= rresp_nxt;
      mask_r      <= mask_nxt;
      mode_r      <= mode_nxt;
      irq_r       <= irq_nxt;
      awready_r   <= awready_nxt;
      wready_r    <= wready_nxt;
      arready_r   <= arready_nxt;
      period_eq_r <= period_eq_nxt;
      wide_prev_r <= wide_prev_nxt;
      wide_seen_r <= wide_seen_nxt;
    end
  end

  // outputs straight from flops
  assign awready_out = awready_r;
  assign wready_out  = wready_r;
  assign arready_out = arready_r;
  assign bvalid_out  = bvalid_r;
  assign bresp_out   = bresp_r;
  assign rvalid_out  = rvalid_r;
  assign rdata_out   = rdata_r;
  assign rresp_out   = rresp_r;
  assign irq_out     = irq_r;
endmodule

// [peripheral_interrupt_flags_chk.sv]
`timescale 1ns/1ps
`include "flags_regs.svh"
module peripheral_interrupt_flags_chk
  import flags_pkg::*;
#(
  parameter int PERIOD_WIDTH = 8,
  parameter int WIDE_WIDTH   = 16
) (
  // clock, reset and peripherals
  input wire logic                    clock_in,
  input wire logic                    rst_n_in,
  input wire periph_events_type       events_in,
  input wire logic [WIDE_WIDTH-1:0]   wide_timer_count_in,
  input wire logic [PERIOD_WIDTH-1:0] period_timer_count_in,
  input wire logic [PERIOD_WIDTH-1:0] period_limit_in,
  // write side of the register bus
  input wire logic                    awvalid_in,
  input wire logic                    awready_out,
  input wire logic [31:0]             awaddr_in,
  input wire logic                    wvalid_in,
  input wire logic                    wready_out,
  input wire logic [31:0]             wdata_in,
  input wire logic [3:0]              wstrb_in,
  input wire logic                    bvalid_out,
  input wire logic [1:0]              bresp_out,
  // interrupt
  input wire logic                    irq_out
);
  default clocking @(posedge clock_in); endclocking
  default disable iff (!rst_n_in);
  logic [31:0] wa_r, wd_r;
  logic        ws_r, eq_r, top_r, roll, rise;
  logic [3:0]  mask_r;
  logic [4:0]  mode_r;
  ////////////////////////////////////////////////////////////////
  // capture accepted write address and data
  always_ff @(posedge clock_in) begin
    if (awvalid_in && awready_out) wa_r <= awaddr_in;
    if (wvalid_in && wready_out) wd_r <= wdata_in;
    if (wvalid_in && wready_out) ws_r <= wstrb_in[0];
  end
  // follow mask and mode, and timer edges
  always_ff @(posedge clock_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      mask_r <= 4'h0;
      mode_r <= 5'h00;
      eq_r   <= 1'b0;
      top_r  <= 1'b0;
    end else begin
      if ($rose(bvalid_out) && ws_r && wa_r[11:0] == `MASK_ADDR) mask_r <= wd_r[3:0];
      if ($rose(bvalid_out) && ws_r && wa_r[11:0] == `MODE_ADDR) mode_r <= wd_r[4:0];
      eq_r  <= period_timer_count_in == period_limit_in;
      top_r <= &wide_timer_count_in;
    end
  end
  assign roll = top_r && wide_timer_count_in == '0;
  assign rise = !eq_r && period_timer_count_in == period_limit_in;
  ////////////////////////////////////////////////////////////////
  AST_RESET_QUIET: assert property ($rose(rst_n_in) |-> !irq_out && !bvalid_out)
    else $error("outputs active just after reset");
  AST_WIDE_ROLL: assert property (roll && mask_r[0] |-> ##2 irq_out)
    else $error("rollover did not raise irq");
  AST_PERIOD_MATCH: assert property (rise && mask_r[1] |-> ##2 irq_out)
    else $error("period match did not raise irq");
  AST_CAPTURE: assert property (events_in.capture_taken && mode_r[3:2] == 2'h1 && mask_r[2] |-> ##2 irq_out)
    else $error("capture did not raise irq");
  AST_COMPARE: assert property (events_in.compare_match && mode_r[3:2] == 2'h2 && mask_r[2] |-> ##2 irq_out)
    else $error("compare match did not raise irq");
  AST_BYTE_DONE: assert property (events_in.byte_done && mode_r[1:0] != 2'h0 && mask_r[3] |-> ##2 irq_out)
    else $error("byte done did not raise irq");
  AST_CTRL_SEQ: assert property ((events_in.start_done || events_in.stop_done
    || events_in.restart_done || events_in.ack_done) && mode_r[1:0] == 2'h3 && mask_r[3] |-> ##2 irq_out)
    else $error("controller sequence did not raise irq");
  AST_IDLE_COND: assert property ((events_in.idle_start_seen || events_in.idle_stop_seen)
    && events_in.serial_idle && mode_r[4] && mask_r[3] |-> ##2 irq_out)
    else $error("idle bus condition did not raise irq");
  AST_IRQ_DROP: assert property ($fell(irq_out) |-> $past(bvalid_out))
    else $error("irq fell without a register write");
  // main scenarios
  cover property (roll && mask_r[0]);
  cover property ($fell(irq_out));
  cover property (bvalid_out && bresp_out == `RESP_SLVERR);
endmodule
bind peripheral_interrupt_flags peripheral_interrupt_flags_chk #(.PERIOD_WIDTH(PERIOD_WIDTH), .WIDE_WIDTH(WIDE_WIDTH))
  chk (.clock_in, .rst_n_in, .events_in, .wide_timer_count_in, .period_timer_count_in, .period_limit_in,
  .awvalid_in, .awready_out, .awaddr_in, .wvalid_in, .wready_out, .wdata_in, .wstrb_in, .bvalid_out,
  .bresp_out, .irq_out);

// [periph_model.sv]
`timescale 1ns/1ps
module periph_model
  import flags_pkg::*;
(
  // clock
  input  wire logic         clock_in,
  // event pulses and timer levels
  output periph_events_type ev_out,
  output logic [15:0]       wide_out,
  output logic [7:0]        cnt_out,
  output logic [7:0]        lim_out
);
  initial begin
    ev_out   = '0;
    wide_out = 16'h1234;
    cnt_out  = 8'h00;
    lim_out  = 8'h40;
  end
  // one-cycle pulse on a chosen event line
  task automatic pulse(input int i);
    @(posedge clock_in);
    ev_out[i] <= 1'b1;
    @(posedge clock_in);
    ev_out[i] <= 1'b0;
  endtask
  // serial unit idle level
  task automatic idle(input logic v);
    @(posedge clock_in);
    ev_out.serial_idle <= v;
  endtask
  // wide timer wraps from all ones to zero
  task automatic roll;
    @(posedge clock_in);
    wide_out <= 16'hffff;
    @(posedge clock_in);
    wide_out <= 16'h0000;
  endtask
  // period timer reaches its limit, then restarts
  task automatic match;
    @(posedge clock_in);
    cnt_out <= lim_out;
    @(posedge clock_in);
    cnt_out <= 8'h00;
  endtask
endmodule

// [peripheral_interrupt_flags_bench.sv]
`timescale 1ns/1ps
`include "flags_regs.svh"
module peripheral_interrupt_flags_bench
  import flags_pkg::*;
;
  logic              clock_in = 0, rst_n_in = 0, awvalid_in = 0, wvalid_in = 0, bready_in = 0;
  logic              arvalid_in = 0, rready_in = 0;
  logic [31:0]       awaddr_in = 0, wdata_in = 0, araddr_in = 0;
  logic [3:0]        wstrb_in = 0;
  logic              awready_out, wready_out, bvalid_out, arready_out, rvalid_out, irq_out;
  logic [31:0]       rdata_out;
  logic [1:0]        bresp_out, rresp_out;
  periph_events_type events_in;
  logic [15:0]       wide_timer_count_in;
  logic [7:0]        period_timer_count_in, period_limit_in;
  int                failures = 0, n_compared = 0, cyc = 0;
  peripheral_interrupt_flags uut (.clock_in, .rst_n_in, .events_in, .wide_timer_count_in, .period_timer_count_in,
    .period_limit_in, .awvalid_in, .awready_out, .awaddr_in, .wvalid_in, .wready_out, .wdata_in, .wstrb_in,
    .bvalid_out, .bready_in, .bresp_out, .arvalid_in, .arready_out, .araddr_in,
    .rvalid_out, .rready_in, .rdata_out, .rresp_out, .irq_out);
  periph_model model (.clock_in, .ev_out(events_in), .wide_out(wide_timer_count_in),
    .cnt_out(period_timer_count_in), .lim_out(period_limit_in));
  ////////////////////////////////////////////////////////////////
  initial begin
    forever #2.5 clock_in = ~clock_in;
  end
  // hang guard
  always @(posedge clock_in) begin
    cyc <= cyc + 1;
    if (cyc == 5000) begin
      failures++;
      tally_and_finish;
    end
  end
  task automatic chk(input string what, input logic [31:0] e, input logic [31:0] g);
    n_compared++;
    if (g !== e) begin
      failures++;
      $display("unexpected %s: expected %h seen %h", what, e, g);
    end
  endtask
  // bus write: address and data together, then the response
  task automatic wr(input logic [31:0] a, d, input logic [3:0] s, input logic [1:0] er);
    logic aw, w, ha, hw;
    @(posedge clock_in);
    aw = 0;
    w = 0;
    awvalid_in <= 1'b1;
    awaddr_in  <= a;
    wvalid_in  <= 1'b1;
    wdata_in   <= d;
    wstrb_in   <= s;
    bready_in  <= 1'b1;
    while (!(aw && w)) begin
      @(negedge clock_in);
      ha = awvalid_in && awready_out;
      hw = wvalid_in && wready_out;
      @(posedge clock_in);
      aw |= ha;
      w |= hw;
      if (ha) awvalid_in <= 1'b0;
      if (hw) wvalid_in <= 1'b0;
    end
    do @(negedge clock_in); while (bvalid_out !== 1'b1);
    chk("bresp", er, bresp_out);
    @(posedge clock_in);
    bready_in <= 1'b0;
  endtask
  // bus read with expected response and data
  task automatic rx(input logic [31:0] a, e, input string what, input logic [1:0] er = `RESP_OKAY);
    @(posedge clock_in);
    arvalid_in <= 1'b1;
    araddr_in  <= a;
    rready_in  <= 1'b1;
    do @(negedge clock_in); while (arready_out !== 1'b1);
    @(posedge clock_in);
    arvalid_in <= 1'b0;
    do @(negedge clock_in); while (rvalid_out !== 1'b1);
    chk(what, e, rdata_out);
    chk("rresp", er, rresp_out);
    @(posedge clock_in);
    rready_in <= 1'b0;
  endtask
  // set a mode, fire one event, read and clear the flags
  task automatic ev_case(input logic [7:0] m, input int i, input logic [31:0] e);
    wr(`MODE_ADDR, {24'h0, m}, 4'h1, `RESP_OKAY);
    model.pulse(i);
    rx(`FLAGS_ADDR, e, "flags after event");
    wr(`FLAGS_ADDR, 32'h0f, 4'h1, `RESP_OKAY);
  endtask
  ////////////////////////////////////////////////////////////////
  task automatic t_reset;
    rx(`FLAGS_ADDR, 32'h0, "flags at reset");
    rx(`MASK_ADDR, 32'h0, "mask at reset");
    rx(`MODE_ADDR, 32'h0, "mode at reset");
    rx(32'h040, 32'h0, "unmapped read", `RESP_SLVERR);
    wr(32'h040, 32'hff, 4'h1, `RESP_SLVERR);
    $display("test reset done");
  endtask
  task automatic t_wide;
    model.roll();
    rx(`FLAGS_ADDR, 32'h1, "overflow flag");
    chk("irq masked", 32'h0, irq_out);
    wr(`MASK_ADDR, 32'h0f, 4'h0, `RESP_OKAY);
    rx(`MASK_ADDR, 32'h0, "mask without lane");
    wr(`MASK_ADDR, 32'hff, 4'h1, `RESP_OKAY);
    rx(`MASK_ADDR, 32'h0f, "mask");
    rx(`FLAGS_ADDR, 32'h1, "overflow flag held");
    chk("irq raised", 32'h1, irq_out);
    wr(`FLAGS_ADDR, 32'h01, 4'h1, `RESP_OKAY);
    rx(`FLAGS_ADDR, 32'h0, "overflow cleared");
    chk("irq dropped", 32'h0, irq_out);
    $display("test overflow done");
  endtask
  task automatic t_period;
    model.match();
    rx(`FLAGS_ADDR, 32'h2, "period flag");
    wr(`FLAGS_ADDR, 32'h02, 4'h1, `RESP_OKAY);
    rx(`FLAGS_ADDR, 32'h0, "period cleared");
    $display("test period done");
  endtask
  task automatic t_capcmp;
    ev_case(8'h04, 1, 32'h4);
    ev_case(8'h08, 0, 32'h4);
    ev_case(8'h0c, 0, 32'h0);
    $display("test capture compare done");
  endtask
  task automatic t_serial;
    model.idle(1'b1);
    ev_case(8'h00, 9, 32'h0);
    ev_case(8'h01, 9, 32'h8);
    ev_case(8'h02, 9, 32'h8);
    ev_case(8'h03, 9, 32'h8);
    ev_case(8'h03, 8, 32'h8);
    ev_case(8'h03, 7, 32'h8);
    ev_case(8'h03, 6, 32'h8);
    ev_case(8'h03, 5, 32'h8);
    ev_case(8'h13, 4, 32'h8);
    ev_case(8'h13, 3, 32'h8);
    ev_case(8'h01, 8, 32'h0);
    $display("test serial done");
  endtask
  task automatic tally_and_finish;
    $display("compared %0d mismatches %0d", n_compared, failures);
    if (failures == 0 && n_compared > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  // main sequence
  initial begin
    repeat (2) @(posedge clock_in);
    rst_n_in <= 1'b1;
    t_reset;
    t_wide;
    t_period;
    t_capcmp;
    t_serial;
    tally_and_finish;
  end
endmodule
